// *** logic/pin_state_consts.vh ***
// pin_state_consts.vh: constants for the standby pin state control block
// assumes: included by logic/pin_state_ctrl.v and logic/pin_cell.v
`ifndef PIN_STATE_CONSTS_VH
`define PIN_STATE_CONSTS_VH

// power state codes on pwr_state_in
`define PWR_STATE_W        3
`define PWR_POR_LVD        3'h0
`define PWR_INT_RESET      3'h1
`define PWR_RUN_SLEEP      3'h2
`define PWR_RTC            3'h3
`define PWR_STOP           3'h4
`define PWR_TIMER          3'h5

// standby_mode_ctrl field position and reset value
`define STBY_PIN_LEVEL_BIT 0
`define STBY_CTRL_W        8
`define STBY_CTRL_RST      8'h00

// per-pin function select codes
`define FUNC_W             2
`define FUNC_GPIO          2'h0
`define FUNC_PERIPH        2'h1
`define FUNC_MAIN_CLK      2'h2

`endif

// *** logic/pin_cell.v ***
// pin_cell.v: output and input gating of one pin from the decoded pin state
// assumes: all inputs synchronous to mclk; hold value captured by the caller
`timescale 1ns/1ps
`include "pin_state_consts.vh"

module pin_cell (
  input  wire        disable_func,
  input  wire        hiz_force,
  input  wire        hold,
  input  wire [1:0]  func_sel,
  input  wire        port_out,
  input  wire        port_oe,
  input  wire        held_out,
  input  wire        held_oe,
  input  wire        periph_out,
  input  wire        periph_oe,
  input  wire        pin_in_sync,
  output reg         pad_out_d,
  output reg         pad_oe_d,
  output reg         in_d
);

  always @* begin
    pad_out_d = 1'b0;
    pad_oe_d  = 1'b0;
    in_d      = 1'b0;
    if (func_sel == `FUNC_MAIN_CLK) begin
      in_d = pin_in_sync;
    end else if (disable_func) begin
      pad_oe_d = 1'b0;
      in_d     = 1'b0;
    end else if (hiz_force) begin
      pad_oe_d = 1'b0;
      in_d     = 1'b0;
    end else if (func_sel == `FUNC_PERIPH) begin
      // a running peripheral keeps control even while held
      pad_out_d = periph_out;
      pad_oe_d  = periph_oe;
      in_d      = pin_in_sync;
    end else if (hold) begin
      pad_out_d = held_out;
      pad_oe_d  = held_oe;
      in_d      = pin_in_sync;
    end else begin
      pad_out_d = port_out;
      pad_oe_d  = port_oe;
      in_d      = pin_in_sync;
    end
  end

endmodule // pin_cell

// *** logic/pin_state_ctrl.v ***
// pin_state_ctrl.v: pin state control across reset, run, sleep and standby
// assumes: power state code and control inputs come from mclk logic;
// pad inputs and external_reset_n_pin are asynchronous and synchronised here
`timescale 1ns/1ps
`include "pin_state_consts.vh"

////////////////////////////////////////////////////////////////////////////////
module pin_state_ctrl #(
  parameter N_PINS = 8
) (
  input  wire                       mclk,
  input  wire                       nrst,
  input  wire                       external_reset_n_pin,
  input  wire [`PWR_STATE_W-1:0]    pwr_state_in,
  input  wire [`STBY_CTRL_W-1:0]    standby_mode_ctrl_wdata,
  input  wire                       standby_mode_ctrl_we,
  input  wire [2*N_PINS-1:0]        func_sel,
  input  wire [N_PINS-1:0]          port_out,
  input  wire [N_PINS-1:0]          port_oe,
  input  wire [N_PINS-1:0]          periph_out,
  input  wire [N_PINS-1:0]          periph_oe,
  input  wire [N_PINS-1:0]          pad_in,
  output reg  [N_PINS-1:0]          pad_out,
  output reg  [N_PINS-1:0]          pad_oe,
  output reg  [N_PINS-1:0]          pin_in,
  output reg  [`STBY_CTRL_W-1:0]    standby_mode_ctrl
);

  ////////////////////////////////////////////////////////////////////////////
  // reset release
  reg                rst_s1_q;
  reg                rst_s2_q;
  wire               rst_n;

  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  assign rst_n = rst_s2_q;

  ////////////////////////////////////////////////////////////////////////////
  // external reset pin synchroniser
  reg                ext_s1_q;
  reg                ext_s2_q;

  // two stages because the reset pin is not timed to mclk; clearing to low
  // keeps the pins in their reset state until the pin is seen high twice
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
    end else begin
      ext_s1_q <= external_reset_n_pin;
      ext_s2_q <= ext_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // standby control register
  wire level_hiz;

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      standby_mode_ctrl <= `STBY_CTRL_RST;
    end else if (standby_mode_ctrl_we) begin
      standby_mode_ctrl <= standby_mode_ctrl_wdata;
    end
  end

  // only the pin level bit acts; the other bits are plain storage
  assign level_hiz = standby_mode_ctrl[`STBY_PIN_LEVEL_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // operating mode decode, one-hot
  localparam M_RESET    = 0;
  localparam M_RUN      = 1;
  localparam M_HOLD     = 2;
  localparam M_HIZ      = 3;

  localparam MODE_RESET = 4'b0001;
  localparam MODE_RUN   = 4'b0010;
  localparam MODE_HOLD  = 4'b0100;
  localparam MODE_HIZ   = 4'b1000;

  reg  [3:0] mode;
  wire       in_reset;
  wire       in_standby;
  wire       hold_mode;
  wire       hiz_mode;

  // the synchronised reset pin overrides any power state code
  always @* begin
    mode = MODE_RUN;
    if (!ext_s2_q) begin
      mode = MODE_RESET;
    end else begin
      case (pwr_state_in)
        `PWR_POR_LVD:   mode = MODE_RESET;
        `PWR_INT_RESET: mode = MODE_RESET;
        `PWR_RUN_SLEEP: mode = MODE_RUN;
        `PWR_RTC,
        `PWR_STOP,
        `PWR_TIMER: begin
          if (level_hiz) begin
            mode = MODE_HIZ;
          end else begin
            mode = MODE_HOLD;
          end
        end
        // unused codes act as run so a bad code never freezes or floats pins
        default:        mode = MODE_RUN;
      endcase
    end
  end

  assign in_reset   = mode[M_RESET];
  assign hold_mode  = mode[M_HOLD];
  assign hiz_mode   = mode[M_HIZ];
  assign in_standby = hold_mode || hiz_mode;

  ////////////////////////////////////////////////////////////////////////////
  // per-pin synchroniser, hold capture and gating
  wire [N_PINS-1:0] pad_out_d;
  wire [N_PINS-1:0] pad_oe_d;
  wire [N_PINS-1:0] in_d;

  genvar i;
  generate
    for (i = 0; i < N_PINS; i = i + 1) begin : g_pin
      reg pad_s1_q;
      reg pad_s2_q;
      reg held_out_q;
      reg held_oe_q;

      // the pad is not timed to mclk, so only pad_s2_q feeds logic
      always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          pad_s1_q <= 1'b0;
          pad_s2_q <= 1'b0;
        end else begin
          pad_s1_q <= pad_in[i];
          pad_s2_q <= pad_s1_q;
        end
      end

      // capture stops in the cycle standby is first seen, so the frozen
      // value is the port drive of the cycle before entry, even when the
      // port changes in the same cycle as the mode
      always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          held_out_q <= 1'b0;
          held_oe_q  <= 1'b0;
        end else if (!in_standby) begin
          held_out_q <= port_out[i];
          held_oe_q  <= port_oe[i];
        end
      end

      pin_cell u_cell (
        .disable_func (in_reset),
        .hiz_force    (hiz_mode),
        .hold         (hold_mode),
        .func_sel     (func_sel[2*i+1:2*i]),
        .port_out     (port_out[i]),
        .port_oe      (port_oe[i]),
        .held_out     (held_out_q),
        .held_oe      (held_oe_q),
        .periph_out   (periph_out[i]),
        .periph_oe    (periph_oe[i]),
        .pin_in_sync  (pad_s2_q),
        .pad_out_d    (pad_out_d[i]),
        .pad_oe_d     (pad_oe_d[i]),
        .in_d         (in_d[i])
      );
    end
  endgenerate

  // one register stage costs a cycle of latency but keeps pads glitch free
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pad_out <= {N_PINS{1'b0}};
      pad_oe  <= {N_PINS{1'b0}};
      pin_in  <= {N_PINS{1'b0}};
    end else begin
      pad_out <= pad_out_d;
      pad_oe  <= pad_oe_d;
      pin_in  <= in_d;
    end
  end

endmodule // pin_state_ctrl

// *** dv/board_pads.sv ***
// board side of the pads
// assumes: chip pad outputs registered on mclk
`timescale 1ns/1ps
module board_pads #(parameter N = 3) (
  input  wire logic [N-1:0] pad_out, pad_oe, ext,
  output wire logic [N-1:0] pad_in
);
  // a pad the chip drives reads back its own level, else the board drives it
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext);
endmodule // board_pads

// *** dv/pin_state_checks_properties.sv ***
// port timing checks of the pin state block
// assumes: bound into pin_state_ctrl, pin 0 gpio, pin 1 peripheral, pin 2 main clock
`timescale 1ns/1ps
`include "pin_state_consts.vh"
module pin_state_checks #(parameter N_PINS = 3) (
  input wire logic                mclk, nrst, external_reset_n_pin, standby_mode_ctrl_we,
  input wire logic [2:0]          pwr_state_in,
  input wire logic [7:0]          standby_mode_ctrl_wdata, standby_mode_ctrl,
  input wire logic [2*N_PINS-1:0] func_sel,
  input wire logic [N_PINS-1:0]   port_out, port_oe, periph_out, periph_oe, pad_in, pad_out, pad_oe, pin_in
);
  wire sb = pwr_state_in inside {`PWR_RTC, `PWR_STOP, `PWR_TIMER};
  wire hiz = sb && standby_mode_ctrl[0];
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  ctrl_write_a: assert property (standby_mode_ctrl_we |=> standby_mode_ctrl == $past(standby_mode_ctrl_wdata))
    else $error("write lost");
  hiz_drive_a: assert property (hiz && func_sel[1:0] == 0 |=> !pad_oe[0]) else $error("driver on");
  input_low_a: assert property (hiz && func_sel[1:0] == 0 |=> !pin_in[0]) else $error("input live");
  reset_off_a: assert property (pwr_state_in <= `PWR_INT_RESET |=> !pad_oe[0] && !pin_in[0])
    else $error("pin live in reset");
  run_follow_a: assert property (external_reset_n_pin [*5] ##0 pwr_state_in == `PWR_RUN_SLEEP
    && func_sel[1:0] == 0 |=> pad_out[0] == $past(port_out[0]) && pad_oe[0] == $past(port_oe[0]))
    else $error("port not followed");
  periph_follow_a: assert property (sb && !standby_mode_ctrl[0] && func_sel[3:2] == 1
    |=> pad_out[1] == $past(periph_out[1]) && pad_oe[1] == $past(periph_oe[1])) else $error("periph lost");
  port_hold_a: assert property (sb && !standby_mode_ctrl[0] && $stable(pwr_state_in) && func_sel[1:0] == 0
    |=> $stable(pad_out[0]) && $stable(pad_oe[0])) else $error("hold lost");
  clk_input_a: assert property (func_sel[5:4] == `FUNC_MAIN_CLK |-> pin_in[2] == $past(pad_in[2], 3))
    else $error("clock input gated");
endmodule // pin_state_checks
bind pin_state_ctrl pin_state_checks #(.N_PINS(N_PINS)) pin_state_checks_inst (
  .mclk(mclk), .nrst(nrst), .external_reset_n_pin(external_reset_n_pin),
  .standby_mode_ctrl_we(standby_mode_ctrl_we), .pwr_state_in(pwr_state_in),
  .standby_mode_ctrl_wdata(standby_mode_ctrl_wdata), .standby_mode_ctrl(standby_mode_ctrl),
  .func_sel(func_sel), .port_out(port_out), .port_oe(port_oe), .periph_out(periph_out),
  .periph_oe(periph_oe), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .pin_in(pin_in));

// *** dv/tb_standby_pin_state_control.sv ***
// testbench of the pin state block
// assumes: pin 0 gpio, pin 1 peripheral, pin 2 main clock input
`timescale 1ns/1ps
`include "pin_state_consts.vh"
module tb_standby_pin_state_control;
  logic       mclk = 0, nrst = 0, xr_n = 1, we = 0;
  logic [2:0] pwr = `PWR_POR_LVD, po = 0, poe = 0, pho = 0, phoe = 0, ext = 0, pad_in, pad_out, pad_oe, pin_in;
  logic [7:0] wd = 0, ctrl;
  logic [2:0] sbm [3] = '{`PWR_RTC, `PWR_STOP, `PWR_TIMER};
  int         n_fail = 0, checks = 0;
  pin_state_ctrl #(.N_PINS(3)) pin_state_ctrl_inst (.mclk(mclk), .nrst(nrst), .external_reset_n_pin(xr_n),
    .pwr_state_in(pwr), .standby_mode_ctrl_wdata(wd), .standby_mode_ctrl_we(we), .func_sel(6'h24),
    .port_out(po), .port_oe(poe), .periph_out(pho), .periph_oe(phoe), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe(pad_oe), .pin_in(pin_in), .standby_mode_ctrl(ctrl));
  board_pads #(.N(3)) board_pads_inst (.pad_out(pad_out), .pad_oe(pad_oe), .ext(ext), .pad_in(pad_in));
  initial forever #2 mclk = ~mclk;
  task automatic chk(input logic [7:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic t_run;
    pwr = `PWR_RUN_SLEEP; po = 3'h1; poe = 3'h1; pho = 3'h2; phoe = 3'h2; step(1);
    chk({pad_out[1:0], pad_oe[1:0]}, 4'hF);
    step(3);
    chk(pin_in[0], 1'h1);
    $display("run test done");
  endtask
  task automatic t_hold;
    wd = 8'h00; we = 1; step(1); we = 0;
    foreach (sbm[i]) begin
      po = 3'h1; poe = 3'h1; pwr = `PWR_RUN_SLEEP; step(2);
      pwr = sbm[i]; po = 3'h0; poe = 3'h0; pho = 3'h0; step(3);
      chk({pad_out[1:0], pad_oe[1:0]}, 4'h7);
      pwr = `PWR_RUN_SLEEP; step(2);
      chk(pad_oe[0], 1'h0);
    end
    $display("hold test done");
  endtask
  task automatic t_hiz;
    wd = 8'h01; we = 1; step(1); we = 0;
    chk(ctrl, 8'h01);
    ext = 3'h7;
    foreach (sbm[i]) begin
      po = 3'h1; poe = 3'h1; pwr = `PWR_RUN_SLEEP; step(4);
      pwr = sbm[i]; step(4);
      chk({pad_oe[1:0], pin_in}, 5'h04);
    end
    pwr = `PWR_RUN_SLEEP; step(4);
    chk(pin_in[0], 1'h1);
    $display("hiz test done");
  endtask
  task automatic t_ext;
    xr_n = 0; step(5);
    chk({pad_oe[1:0], pin_in}, 5'h04);
    xr_n = 1; step(5);
    chk(pad_oe[0], 1'h1);
    pwr = `PWR_INT_RESET; step(2);
    chk({pad_oe[1:0], pin_in[1:0]}, 4'h0);
    $display("reset test done");
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge mclk);
    #1 nrst = 1;
    step(4);
    t_run;
    t_hold;
    t_hiz;
    t_ext;
    complete_run;
  end
endmodule // tb_standby_pin_state_control
